// ==== inc/secure_cfg_regs.svh ====
// Register offsets, field positions and reset values of the configuration field bank.
// Assumes byte addresses on an AXI4-Lite bus with one 32-bit word per register.
`ifndef SECURE_CFG_REGS_SVH
`define SECURE_CFG_REGS_SVH

`define ADDR_ANSWER_LO    8'h00
`define ADDR_ANSWER_HI    8'h04
`define ADDR_FAB_CODE     8'h08
`define ADDR_TEST_FIELD   8'h0c
`define ADDR_MAKER_CODE   8'h10
`define ADDR_HISTORY_LO   8'h14
`define ADDR_HISTORY_HI   8'h18
`define ADDR_ISSUER_0     8'h1c
`define ADDR_OPTION_CFG   8'h2c
`define ADDR_FUSE_CTRL    8'h30
`define ADDR_QUERY        8'h34
`define ADDR_STATUS       8'h38
`define ADDR_EVENT        8'h3c
`define ADDR_COUNTERS     8'h40
`define ZONE_BLOCK        2'b10
`define ZONE_COUNT        16

`define ALL_ONES_32       32'hffffffff
`define ALL_ONES_16       16'hffff
`define ALL_ONES_8        8'hff
`define CS_DEFAULT        4'hb
`define MODE_OPEN         2'b11
`define MODE_WRITE_ONLY   2'b10
`define MODE_DUAL         2'b00

// Option register bits
`define OPT_SUPERVISOR    7
`define OPT_CHECKSUM      6
`define OPT_TRIAL_OFF     5
`define OPT_EIGHT         4

// Zone access bits
`define ZA_ENC_REQ        3
`define ZA_WRITE_LOCK     2
`define ZA_MODIFY_OFF     1
`define ZA_PROGRAM_ONLY   0

// Query word fields
`define Q_WRITE           4
`define Q_READ_PW         5
`define Q_WRITE_PW        6
`define Q_AUTH_KEY        7
`define Q_PROG_KEY        8
`define Q_ENC_ACTIVE      9
`define Q_SUPER_PW        10

// Event word bits
`define EV_AUTH_FAIL      0
`define EV_PW_FAIL        1
`define EV_CHECKSUM       2
`define EV_MAC_READ       3

// Fuse word bits
`define FUSE_FACTORY      0
`define FUSE_PERSONAL     1

`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

// ==== inc/secure_cfg_pkg.sv ====
// Types shared by the configuration field bank.
// Assumes the offsets and field positions of secure_cfg_regs.svh.
package secure_cfg_pkg;
   typedef logic [7:0]  byte_t;
   typedef logic [31:0] word_t;
   typedef logic [1:0]  mode_t;
endpackage : secure_cfg_pkg

// ==== logic/secure_config_memory_policy.sv ====
// Configuration field bank and zone access policy of a secure serial memory, as an
// AXI4-Lite slave. Assumes secure_cfg_pkg is compiled first and one clock, mclk.
//
// Our own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "secure_cfg_regs.svh"

module secure_config_memory_policy #(
   parameter logic [63:0] PROD_HISTORY = 64'h0123456789abcdef  // Arbitrary value
) (
   input  wire logic        mclk,         // 250 MHz clock
   input  wire logic        srst,         // Synchronous reset, high
   input  wire logic [7:0]  awaddr,       // Write address
   input  wire logic        awvalid,      // Write address valid
   output logic             awready,      // Write address ready
   input  wire logic [31:0] wdata,        // Write data
   input  wire logic [3:0]  wstrb,        // Write byte strobes
   input  wire logic        wvalid,       // Write data valid
   output logic             wready,       // Write data ready
   output logic [1:0]       bresp,        // Write response
   output logic             bvalid,       // Write response valid
   input  wire logic        bready,       // Write response ready
   input  wire logic [7:0]  araddr,       // Read address
   input  wire logic        arvalid,      // Read address valid
   output logic             arready,      // Read address ready
   output logic [31:0]      rdata,        // Read data
   output logic [1:0]       rresp,        // Read response
   output logic             rvalid,       // Read data valid
   input  wire logic        rready,       // Read data ready
   output logic             accessGrant,  // Last query granted
   output logic             chipSelected, // Last command hits this device
   output logic             cryptoReset   // One-cycle crypto state reset
);

   // Merge strobed bytes of new data into an old word
   function automatic secure_cfg_pkg::word_t mergeBytes(input secure_cfg_pkg::word_t old,
                                                        input secure_cfg_pkg::word_t nw,
                                                        input logic [3:0] strb);
      secure_cfg_pkg::word_t res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) res[i*8 +: 8] = nw[i*8 +: 8];
      end
      return res;
   endfunction : mergeBytes

   // Next attempt counter value after one failure
   function automatic secure_cfg_pkg::byte_t stepCounter(input secure_cfg_pkg::byte_t cur,
                                                         input logic eightN);
      if (!eightN) return {cur[6:0], 1'b0};
      return {cur[6:4], 1'b0, cur[2:0], 1'b0};
   endfunction : stepCounter

   // Field storage
   logic [63:0]           answerBytes;
   logic [15:0]           fabCode;
   logic [15:0]           testField;
   logic [31:0]           makerCode;
   logic [127:0]          issuerCode;
   secure_cfg_pkg::byte_t optionCfg;
   secure_cfg_pkg::byte_t zoneAccess [`ZONE_COUNT];
   logic                  factoryFuse;
   logic                  personalFuse;
   logic [31:0]           queryWord;
   logic [5:0]            statusBits;
   secure_cfg_pkg::byte_t authCounter;
   secure_cfg_pkg::byte_t pwCounter;

   // Bus handshake state
   logic        awHeld;
   logic        wHeld;
   logic        arHeld;
   logic [7:0]  awAddrReg;
   logic [31:0] wDataReg;
   logic [3:0]  wStrbReg;
   logic [7:0]  arAddrReg;
   logic        wrFire;
   logic        rdFire;
   logic        zoneWr;
   logic [3:0]  zoneWrIdx;
   logic [1:0]  issuerWrIdx;
   logic        issuerWr;

   assign wrFire      = awHeld && wHeld && !bvalid;
   assign rdFire      = arHeld && !rvalid;
   assign zoneWr      = wrFire && (awAddrReg[7:6] == `ZONE_BLOCK);
   assign zoneWrIdx   = awAddrReg[5:2];
   assign issuerWrIdx = 2'(awAddrReg[5:2] - `ADDR_ISSUER_0 / 4);
   assign issuerWr    = wrFire && (awAddrReg >= `ADDR_ISSUER_0) && (awAddrReg < `ADDR_OPTION_CFG);

   // Write address channel
   always_ff @(posedge mclk) begin
      if (srst) begin
         awHeld    <= 1'b0;
         awready   <= 1'b0;
         awAddrReg <= 8'h00;
      end else if (awvalid && awready) begin
         awHeld    <= 1'b1;
         awready   <= 1'b0;
         awAddrReg <= awaddr;
      end else begin
         if (wrFire) awHeld <= 1'b0;
         if (!awHeld && !bvalid) awready <= 1'b1;
      end
   end

   // Write data channel
   always_ff @(posedge mclk) begin
      if (srst) begin
         wHeld    <= 1'b0;
         wready   <= 1'b0;
         wDataReg <= 32'h00000000;
         wStrbReg <= 4'h0;
      end else if (wvalid && wready) begin
         wHeld    <= 1'b1;
         wready   <= 1'b0;
         wDataReg <= wdata;
         wStrbReg <= wstrb;
      end else begin
         if (wrFire) wHeld <= 1'b0;
         if (!wHeld && !bvalid) wready <= 1'b1;
      end
   end

   // Write response; unmapped or read-only words still answer OKAY
   always_ff @(posedge mclk) begin
      if (srst) begin
         bvalid <= 1'b0;
         bresp  <= `RESP_OKAY;
      end else if (wrFire) begin
         bvalid <= 1'b1;
         bresp  <= `RESP_OKAY;
      end else if (bvalid && bready) begin
         bvalid <= 1'b0;
      end
   end

   // Factory-fuse fields
   always_ff @(posedge mclk) begin
      if (srst) begin
         answerBytes <= {`ALL_ONES_32, `ALL_ONES_32};
         fabCode     <= `ALL_ONES_16;
      end else if (wrFire && !factoryFuse) begin
         if (awAddrReg == `ADDR_ANSWER_LO)
            answerBytes[31:0] <= mergeBytes(answerBytes[31:0], wDataReg, wStrbReg);
         if (awAddrReg == `ADDR_ANSWER_HI)
            answerBytes[63:32] <= mergeBytes(answerBytes[63:32], wDataReg, wStrbReg);
         if (awAddrReg == `ADDR_FAB_CODE)
            fabCode <= 16'(mergeBytes({16'h0000, fabCode}, wDataReg, wStrbReg));
      end
   end

   // Open test field, free of every condition
   always_ff @(posedge mclk) begin
      if (srst) testField <= `ALL_ONES_16;
      else if (wrFire && awAddrReg == `ADDR_TEST_FIELD)
         testField <= 16'(mergeBytes({16'h0000, testField}, wDataReg, wStrbReg));
   end

   // Personalization-fuse fields; locked writes fall through unchanged
   always_ff @(posedge mclk) begin
      if (srst) begin
         makerCode  <= `ALL_ONES_32;
         issuerCode <= {4{`ALL_ONES_32}};
      end else if (wrFire && !personalFuse) begin
         if (awAddrReg == `ADDR_MAKER_CODE)
            makerCode <= mergeBytes(makerCode, wDataReg, wStrbReg);
         if (issuerWr)
            issuerCode[issuerWrIdx*32 +: 32] <=
               mergeBytes(issuerCode[issuerWrIdx*32 +: 32], wDataReg, wStrbReg);
      end
   end

   // Option register and zone access registers take effect at once
   always_ff @(posedge mclk) begin
      if (srst) begin
         optionCfg <= `ALL_ONES_8;
         for (int i = 0; i < `ZONE_COUNT; i++) zoneAccess[i] <= `ALL_ONES_8;
      end else if (wrFire && !personalFuse) begin
         if (awAddrReg == `ADDR_OPTION_CFG && wStrbReg[0])
            optionCfg <= wDataReg[7:0];
         if (zoneWr && wStrbReg[0])
            zoneAccess[zoneWrIdx] <= wDataReg[7:0];
      end
   end

   // Fuses blow by writing one and clear only on srst
   always_ff @(posedge mclk) begin
      if (srst) begin
         factoryFuse  <= 1'b0;
         personalFuse <= 1'b0;
      end else if (wrFire && awAddrReg == `ADDR_FUSE_CTRL && wStrbReg[0]) begin
         if (wDataReg[`FUSE_FACTORY])  factoryFuse  <= 1'b1;
         if (wDataReg[`FUSE_PERSONAL]) personalFuse <= 1'b1;
      end
   end

   // Access query word
   always_ff @(posedge mclk) begin
      if (srst) queryWord <= 32'h00000000;
      else if (wrFire && awAddrReg == `ADDR_QUERY)
         queryWord <= mergeBytes(queryWord, wDataReg, wStrbReg);
   end

   // Policy evaluation for the queried zone
   secure_cfg_pkg::byte_t za;
   secure_cfg_pkg::mode_t pwMode;
   secure_cfg_pkg::mode_t authMode;
   logic isWrite;
   logic pwOk;
   logic authOk;
   logic encOk;
   logic modOk;
   logic keyAlive;
   logic progOnly;
   logic next_grant;
   logic next_cs;

   assign za       = zoneAccess[queryWord[3:0]];
   assign pwMode   = za[7:6];
   assign authMode = za[5:4];
   assign isWrite  = queryWord[`Q_WRITE];
   assign keyAlive = (authCounter != 8'h00) || !optionCfg[`OPT_TRIAL_OFF];

   always_comb begin
      // Password checks; a verified write password also opens reads
      if (pwMode == `MODE_OPEN) pwOk = 1'b1;
      else if (pwMode == `MODE_WRITE_ONLY) pwOk = !isWrite || queryWord[`Q_WRITE_PW];
      else if (isWrite) pwOk = queryWord[`Q_WRITE_PW];
      else pwOk = queryWord[`Q_READ_PW] || queryWord[`Q_WRITE_PW];
      // Authentication checks; dual mode grants reads and writes to the auth or program key alike
      case (authMode)
         `MODE_OPEN:       authOk = 1'b1;
         `MODE_WRITE_ONLY: authOk = !isWrite || (queryWord[`Q_AUTH_KEY] && keyAlive);
         `MODE_DUAL:       authOk = (queryWord[`Q_AUTH_KEY] || queryWord[`Q_PROG_KEY])
                                    && keyAlive;
         default:          authOk = queryWord[`Q_AUTH_KEY] && keyAlive;
      endcase
      encOk = za[`ZA_ENC_REQ] || queryWord[`Q_ENC_ACTIVE];
      modOk = !isWrite || za[`ZA_MODIFY_OFF];
      progOnly = !za[`ZA_PROGRAM_ONLY] || (authMode == `MODE_DUAL
                 && !queryWord[`Q_AUTH_KEY]);
      next_grant = pwOk && authOk && encOk && modOk;
      next_cs = (queryWord[23:20] == `CS_DEFAULT)
                || (queryWord[23:20] == optionCfg[3:0]);
   end

   // Registered policy answers
   always_ff @(posedge mclk) begin
      if (srst) begin
         statusBits   <= 6'h00;
         accessGrant  <= 1'b0;
         chipSelected <= 1'b0;
      end else begin
         statusBits[0] <= next_grant;
         statusBits[1] <= progOnly;
         statusBits[2] <= !za[`ZA_WRITE_LOCK];
         statusBits[3] <= next_cs;
         statusBits[4] <= queryWord[`Q_SUPER_PW] && !optionCfg[`OPT_SUPERVISOR];
         statusBits[5] <= !optionCfg[`OPT_TRIAL_OFF];
         accessGrant   <= next_grant;
         chipSelected  <= next_cs;
      end
   end

   // Attempt counters and crypto reset events
   logic evFire;
   assign evFire = wrFire && awAddrReg == `ADDR_EVENT && wStrbReg[0];

   always_ff @(posedge mclk) begin
      if (srst) begin
         authCounter <= `ALL_ONES_8;
         pwCounter   <= `ALL_ONES_8;
         cryptoReset <= 1'b0;
      end else begin
         cryptoReset <= evFire && ((wDataReg[`EV_CHECKSUM] && optionCfg[`OPT_CHECKSUM])
                        || (wDataReg[`EV_MAC_READ] && optionCfg[`OPT_TRIAL_OFF]));
         if (evFire && wDataReg[`EV_AUTH_FAIL])
            authCounter <= stepCounter(authCounter, optionCfg[`OPT_EIGHT]);
         if (evFire && wDataReg[`EV_PW_FAIL])
            pwCounter <= stepCounter(pwCounter, optionCfg[`OPT_EIGHT]);
      end
   end

   // Read channel
   logic [31:0] rdValue;
   logic        rdErr;
   logic [1:0]  rdIssuerIdx;
   assign rdIssuerIdx = 2'(arAddrReg[5:2] - `ADDR_ISSUER_0 / 4);

   always_comb begin
      rdValue = 32'h00000000;
      rdErr   = 1'b0;
      if (arAddrReg[7:6] == `ZONE_BLOCK) rdValue = {24'h000000, zoneAccess[arAddrReg[5:2]]};
      else if (arAddrReg >= `ADDR_ISSUER_0 && arAddrReg < `ADDR_OPTION_CFG)
         rdValue = issuerCode[rdIssuerIdx*32 +: 32];
      else begin
         case (arAddrReg)
            `ADDR_ANSWER_LO:  rdValue = answerBytes[31:0];
            `ADDR_ANSWER_HI:  rdValue = answerBytes[63:32];
            `ADDR_FAB_CODE:   rdValue = {16'h0000, fabCode};
            `ADDR_TEST_FIELD: rdValue = {16'h0000, testField};
            `ADDR_MAKER_CODE: rdValue = makerCode;
            `ADDR_HISTORY_LO: rdValue = PROD_HISTORY[31:0];
            `ADDR_HISTORY_HI: rdValue = PROD_HISTORY[63:32];
            `ADDR_OPTION_CFG: rdValue = {24'h000000, optionCfg};
            `ADDR_FUSE_CTRL:  rdValue = {30'h00000000, personalFuse, factoryFuse};
            `ADDR_QUERY:      rdValue = queryWord;
            `ADDR_STATUS:     rdValue = {26'h0000000, statusBits};
            `ADDR_EVENT:      rdValue = 32'h00000000;
            `ADDR_COUNTERS:   rdValue = {16'h0000, pwCounter, authCounter};
            default:          rdErr   = 1'b1;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         arHeld    <= 1'b0;
         arready   <= 1'b0;
         arAddrReg <= 8'h00;
      end else if (arvalid && arready) begin
         arHeld    <= 1'b1;
         arready   <= 1'b0;
         arAddrReg <= araddr;
      end else begin
         if (rdFire) arHeld <= 1'b0;
         if (!arHeld && !rvalid) arready <= 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         rvalid <= 1'b0;
         rdata  <= 32'h00000000;
         rresp  <= `RESP_OKAY;
      end else if (rdFire) begin
         rvalid <= 1'b1;
         rdata  <= rdValue;
         rresp  <= rdErr ? `RESP_SLVERR : `RESP_OKAY;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end
   end

   // Checks on the policy and the field locks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   sequence s_test_write;
      wrFire && awAddrReg == `ADDR_TEST_FIELD && wStrbReg[1:0] == 2'b11;
   endsequence

   a_history_read_fixed: assert property (rvalid && rresp == `RESP_OKAY &&
      $past(rdFire) && $past(arAddrReg) == `ADDR_HISTORY_LO |-> rdata == PROD_HISTORY[31:0])
      else $error("production history read wrong");
   a_answer_locked: assert property (factoryFuse && $past(factoryFuse) |->
      $stable(answerBytes)) else $error("reset answer changed after fuse");
   a_fab_locked: assert property (factoryFuse && $past(factoryFuse) |->
      $stable(fabCode)) else $error("fabrication code changed after fuse");
   a_test_field_open: assert property (s_test_write |=>
      testField == $past(wDataReg[15:0])) else $error("test field write lost");
   a_maker_locked: assert property (personalFuse && $past(personalFuse) |->
      $stable(makerCode)) else $error("maker code changed after fuse");
   a_issuer_locked: assert property (personalFuse && $past(personalFuse) |->
      $stable(issuerCode)) else $error("issuer code changed after fuse");
   a_cs_decode: assert property (##1 chipSelected == ($past(queryWord[23:20]) == 4'hb ||
      $past(queryWord[23:20]) == $past(optionCfg[3:0]))) else $error("chip select wrong");
   a_counter_step: assert property (evFire && wDataReg[`EV_AUTH_FAIL] &&
      optionCfg[`OPT_EIGHT] |=> authCounter == {$past(authCounter[6:4]), 1'b0,
      $past(authCounter[2:0]), 1'b0}) else $error("four-trial step wrong");
   a_checksum_reset: assert property (evFire && wDataReg[`EV_CHECKSUM] &&
      optionCfg[`OPT_CHECKSUM] |=> cryptoReset ##1 !cryptoReset[*1])
      else $error("checksum read did not reset crypto");
   a_modify_blocks: assert property (##1 $past(isWrite && !za[`ZA_MODIFY_OFF]) |->
      !accessGrant) else $error("modify-forbidden zone granted write");

endmodule : secure_config_memory_policy

// ==== verif/axi_host_model.sv ====
// AXI4-Lite host that reaches the configuration field bank.
// Assumes one clock, mclk, and a slave that answers every request.
`timescale 1ns/1ps
module axi_host_model (
   input  wire logic        mclk,    // Bus clock
   output logic [7:0]       awaddr,  // Write address
   output logic             awvalid, // Write address valid
   input  wire logic        awready, // Write address ready
   output logic [31:0]      wdata,   // Write data
   output logic [3:0]       wstrb,   // Byte strobes
   output logic             wvalid,  // Write data valid
   input  wire logic        wready,  // Write data ready
   input  wire logic [1:0]  bresp,   // Write response
   input  wire logic        bvalid,  // Write response valid
   output logic             bready,  // Write response ready
   output logic [7:0]       araddr,  // Read address
   output logic             arvalid, // Read address valid
   input  wire logic        arready, // Read address ready
   input  wire logic [31:0] rdata,   // Read data
   input  wire logic [1:0]  rresp,   // Read response
   input  wire logic        rvalid,  // Read data valid
   output logic             rready   // Read data ready
);
   logic [1:0] lastResp; // Response of the last write

   // Idle bus from time zero
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
   end

   // One write; each channel held until its own handshake
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge mclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      lastResp = bresp;
      bready <= 1'b0;
   endtask : wr

   // One read; data and response taken at the rvalid edge
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge mclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd
endmodule : axi_host_model

// ==== verif/secure_config_memory_policy_tb.sv ====
// Self-checking bench for the configuration field bank.
// Assumes the host model drives every bus input of the bank.
`timescale 1ns/1ps
`include "secure_cfg_regs.svh"
module secure_config_memory_policy_tb;
   localparam logic [63:0] HIST = 64'h5a3c0f1e96d2b487; // Arbitrary value
   logic        mclk = 1'b0;
   logic        srst = 1'b1;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rv;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, rr;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic        accessGrant, chipSelected, cryptoReset, sawReset;
   int          num_errors = 0;
   int          comparisons = 0;

   secure_config_memory_policy #(.PROD_HISTORY(HIST)) u_dut (
      .mclk(mclk), .srst(srst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .accessGrant(accessGrant), .chipSelected(chipSelected), .cryptoReset(cryptoReset));
   axi_host_model u_host (
      .mclk(mclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

   // Clock and crypto reset pulse catcher
   always #2 mclk = ~mclk;
   always @(posedge mclk) if (cryptoReset === 1'b1) sawReset <= 1'b1;

   task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("FAIL %s expected %h seen %h", n, exp, seen);
      end
   endtask : check

   task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
      u_host.rd(a, rv, rr);
      check(n, rv & m, e);
   endtask : rdchk

   // Query word, then the level answer after it settles
   task automatic query(input logic [31:0] q, input logic c, input logic g);
      u_host.wr(`ADDR_QUERY, q, 4'hf);
      repeat (2) @(posedge mclk);
      check("chipSelected", {31'h0, chipSelected}, {31'h0, c});
      check("accessGrant", {31'h0, accessGrant}, {31'h0, g});
   endtask : query

   task automatic t_defaults();
      rdchk("answer", `ADDR_ANSWER_LO, 32'hffffffff, 32'hffffffff);
      rdchk("test", `ADDR_TEST_FIELD, 32'hffff, 32'hffff);
      rdchk("issuer", `ADDR_ISSUER_0 + 8'h0c, 32'hffffffff, 32'hffffffff);
      rdchk("option", `ADDR_OPTION_CFG, 32'hff, 32'hff);
      rdchk("zone15", 8'hbc, 32'hff, 32'hff);
      rdchk("histlo", `ADDR_HISTORY_LO, 32'hffffffff, HIST[31:0]);
      u_host.wr(`ADDR_HISTORY_HI, 32'h0, 4'hf);
      check("bresp", {30'h0, u_host.lastResp}, {30'h0, `RESP_OKAY});
      rdchk("histhi", `ADDR_HISTORY_HI, 32'hffffffff, HIST[63:32]);
      u_host.rd(8'h50, rv, rr);
      check("unmapped", {30'h0, rr}, {30'h0, `RESP_SLVERR});
   endtask : t_defaults

   task automatic t_select_policy();
      u_host.wr(`ADDR_OPTION_CFG, 32'hf5, 4'h1);
      query(32'h00500000, 1'b1, 1'b1);
      query(32'h00b00000, 1'b1, 1'b1);
      query(32'h00300000, 1'b0, 1'b1);
      u_host.wr(8'h80, 32'hbf, 4'h1);
      query(32'h00b00010, 1'b1, 1'b0);
      query(32'h00b00050, 1'b1, 1'b1);
      query(32'h00b00000, 1'b1, 1'b1);
      // Modify forbidden, read password, required encryption, dual key zones
      u_host.wr(8'h84, 32'hfd, 4'h1);
      u_host.wr(8'h88, 32'h37, 4'h1);
      u_host.wr(8'h8c, 32'hcf, 4'h1);
      query(32'h00b00011, 1'b1, 1'b0);
      query(32'h00b00001, 1'b1, 1'b1);
      query(32'h00b00202, 1'b1, 1'b0);
      query(32'h00b00262, 1'b1, 1'b1);
      query(32'h00b00042, 1'b1, 1'b0);
      query(32'h00b00003, 1'b1, 1'b0);
      u_host.wr(`ADDR_OPTION_CFG, 32'h75, 4'h1);
      query(32'h00b00503, 1'b1, 1'b1);
      rdchk("status", `ADDR_STATUS, 32'h32, 32'h12);
   endtask : t_select_policy

   task automatic t_counters();
      u_host.wr(`ADDR_EVENT, 32'h1, 4'hf);
      rdchk("auth1", `ADDR_COUNTERS, 32'hff, 32'hee);
      u_host.wr(`ADDR_EVENT, 32'h1, 4'hf);
      rdchk("auth2", `ADDR_COUNTERS, 32'hff, 32'hcc);
      u_host.wr(`ADDR_OPTION_CFG, 32'he5, 4'h1);
      u_host.wr(`ADDR_EVENT, 32'h2, 4'hf);
      rdchk("pw1", `ADDR_COUNTERS, 32'hff00, 32'hfe00);
   endtask : t_counters

   task automatic t_checksum(input logic [31:0] opt, input logic [31:0] ev, input logic e);
      u_host.wr(`ADDR_OPTION_CFG, opt, 4'h1);
      sawReset <= 1'b0;
      u_host.wr(`ADDR_EVENT, ev, 4'hf);
      repeat (3) @(posedge mclk);
      check("cryptoReset", {31'h0, sawReset}, {31'h0, e});
   endtask : t_checksum

   task automatic t_fuses();
      u_host.wr(`ADDR_ANSWER_LO, 32'h11223344, 4'hf);
      u_host.wr(`ADDR_FAB_CODE, 32'h0000abcd, 4'hf);
      u_host.wr(`ADDR_FUSE_CTRL, 32'h1, 4'hf);
      u_host.wr(`ADDR_ANSWER_LO, 32'h55667788, 4'hf);
      u_host.wr(`ADDR_FAB_CODE, 32'h00001234, 4'hf);
      u_host.wr(`ADDR_TEST_FIELD, 32'h0000beef, 4'hf);
      rdchk("answer", `ADDR_ANSWER_LO, 32'hffffffff, 32'h11223344);
      rdchk("fab", `ADDR_FAB_CODE, 32'hffff, 32'habcd);
      rdchk("test", `ADDR_TEST_FIELD, 32'hffff, 32'hbeef);
      u_host.wr(`ADDR_MAKER_CODE, 32'hc0de0001, 4'hf);
      u_host.wr(`ADDR_ISSUER_0, 32'h0bad0f0d, 4'hf);
      u_host.wr(`ADDR_FUSE_CTRL, 32'h2, 4'hf);
      u_host.wr(`ADDR_MAKER_CODE, 32'h0, 4'hf);
      u_host.wr(`ADDR_ISSUER_0, 32'h0, 4'hf);
      rdchk("maker", `ADDR_MAKER_CODE, 32'hffffffff, 32'hc0de0001);
      rdchk("issuer", `ADDR_ISSUER_0, 32'hffffffff, 32'h0bad0f0d);
   endtask : t_fuses

   task automatic conclude();
      if (num_errors == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : conclude

   // Watchdog well beyond the expected run
   initial begin
      #200000;
      num_errors++;
      conclude();
   end

   // Reset for three cycles, then the scenarios
   initial begin
      sawReset = 1'b0;
      repeat (3) @(posedge mclk);
      srst <= 1'b0;
      repeat (2) @(posedge mclk);
      t_defaults();
      t_select_policy();
      t_counters();
      t_checksum(32'he5, 32'h4, 1'b1);
      t_checksum(32'ha5, 32'h4, 1'b0);
      t_checksum(32'ha5, 32'h8, 1'b1);
      t_checksum(32'h85, 32'h8, 1'b0);
      t_fuses();
      conclude();
   end
endmodule : secure_config_memory_policy_tb
